// File: verilog/brl_defs.svh
// named constants of the bootstrap ram loader
`ifndef BRL_DEFS_SVH
`define BRL_DEFS_SVH

`define BRL_COUNT_LIMIT 8'hb0
`define BRL_RAM1_START 16'h0050
`define BRL_RAM1_END 16'h00ff
`define BRL_RAM2_START 16'h0100
`define BRL_RAM2_END 16'h01ff
`define BRL_RAM3_START 16'h0250
`define BRL_RAM3_END 16'h02ff
`define BRL_EXEC_ADDR 16'h0051

`define BRL_VEC_SERIAL 16'h0063
`define BRL_VEC_TOVF 16'h0060
`define BRL_VEC_OCMP 16'h005d
`define BRL_VEC_ICAP 16'h005a
`define BRL_VEC_EXT 16'h0057
`define BRL_VEC_TRAP 16'h0054

`define BRL_SEL_TRAP 3'h0
`define BRL_SEL_EXT 3'h1
`define BRL_SEL_ICAP 3'h2
`define BRL_SEL_OCMP 3'h3
`define BRL_SEL_TOVF 3'h4
`define BRL_SEL_SERIAL 3'h5

`define BRL_CLK_KHZ 250000
`define BRL_QUIET_MS 5

`define BRL_MC_DIV_LAST 2'h3
`define BRL_SETTLE_LAST 2'h3
`define BRL_T_HO 6'h05
`define BRL_T_ADR 6'h10
`define BRL_T_EXR 6'h1e
`define BRL_T_CR_LAST 6'h30

`endif

// File: verilog/brl_pkg.sv
// types of the bootstrap ram loader
`default_nettype none
package brl_pkg;

   typedef enum logic [2:0] {
      ST_STRAP = 3'b000,
      ST_HEAD = 3'b001,
      ST_COUNT = 3'b010,
      ST_EXT = 3'b011,
      ST_PAR = 3'b100,
      ST_RUN = 3'b101,
      ST_IDLE = 3'b110
   } brl_state_e;

   typedef enum logic [1:0] {
      MODE_NONE = 2'b00,
      MODE_JUMP = 2'b01,
      MODE_SERIAL = 2'b10,
      MODE_PAR = 2'b11
   } brl_mode_e;

   typedef struct packed {
      brl_state_e st;
      brl_mode_e mode;
      logic [2:0] pd_s1;
      logic [2:0] pd_s2;
      logic [1:0] settle;
      logic hs_s1;
      logic hs_s2;
      logic hs_prev;
      logic [7:0] dat_s1;
      logic [7:0] dat_s2;
      logic [1:0] div;
      logic tick;
      logic [5:0] mc;
      logic hs_out;
      logic seen;
      logic sampled;
      logic [15:0] par_addr;
      logic push;
      logic [7:0] push_data;
      logic [15:0] wr_addr;
      logic [7:0] count;
      logic [20:0] quiet;
      logic ram_we;
      logic [15:0] ram_addr;
      logic [7:0] ram_wdata;
      logic run;
      logic [15:0] run_addr;
      logic vec_remap;
      logic [15:0] vec_target;
   } brl_loader_s;

endpackage
`default_nettype wire

// File: verilog/brl_stream_if.sv
// byte stream between the loader and its fifo
`timescale 1ns/100ps
`default_nettype none
interface brl_stream_if #(parameter int WIDTH = 8);
   logic push_valid;
   logic [WIDTH-1:0] push_data;
   logic push_ready;
   logic pop_valid;
   logic [WIDTH-1:0] pop_data;
   logic pop_ready;

   modport fifo_side (
      input push_valid,
      input push_data,
      output push_ready,
      output pop_valid,
      output pop_data,
      input pop_ready
   );

   modport user_side (
      output push_valid,
      output push_data,
      input push_ready,
      input pop_valid,
      input pop_data,
      output pop_ready
   );
endinterface
`default_nettype wire

// File: verilog/brl_fifo.sv
// byte fifo with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module brl_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clock,
   input wire logic reset,
   brl_stream_if.fifo_side s
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW:0] count;
      logic [AW-1:0] rd;
      logic [AW-1:0] wr;
      logic in_ready;
   } brl_fifo_s;

   brl_fifo_s q_ff;
   brl_fifo_s nxt_q;
   logic do_push;
   logic do_pop;

   assign s.push_ready = q_ff.in_ready;
   assign s.pop_valid = (q_ff.count != '0);
   assign s.pop_data = q_ff.mem[q_ff.rd];

   always_comb begin
      nxt_q = q_ff;
      do_push = s.push_valid && q_ff.in_ready;
      do_pop = s.pop_ready && (q_ff.count != '0);
      if (do_push) begin
         nxt_q.mem[q_ff.wr] = s.push_data;
         nxt_q.wr = (q_ff.wr == AW'(DEPTH - 1)) ? '0 : q_ff.wr + 1'b1;
      end
      if (do_pop) begin
         nxt_q.rd = (q_ff.rd == AW'(DEPTH - 1)) ? '0 : q_ff.rd + 1'b1;
      end
      if (do_push && !do_pop) begin
         nxt_q.count = q_ff.count + 1'b1;
      end else if (do_pop && !do_push) begin
         nxt_q.count = q_ff.count - 1'b1;
      end
      nxt_q.in_ready = (nxt_q.count != DEPTH_C);
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         q_ff <= '0;
         q_ff.in_ready <= 1'b1;
      end else begin
         q_ff <= nxt_q;
      end
   end
endmodule
`default_nettype wire

// File: verilog/brl_loader.sv
// bootstrap ram loader: strap decode, serial and parallel load, vectors
`timescale 1ns/100ps
`default_nettype none
`include "brl_defs.svh"
module brl_loader #(
   parameter int unsigned QUIET_CYCLES = `BRL_QUIET_MS * `BRL_CLK_KHZ
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic port_d_bit2,
   input wire logic port_d_bit3,
   input wire logic port_d_bit4,
   input wire logic ser_valid,
   input wire logic [7:0] ser_data,
   output logic ser_ready,
   input wire logic [7:0] par_data,
   input wire logic handshake_in_pin,
   output logic handshake_out_pin,
   output logic [15:0] par_addr,
   input wire logic ram_ready,
   output logic ram_we,
   output logic [15:0] ram_addr,
   output logic [7:0] ram_wdata,
   output logic run,
   output logic [15:0] run_addr,
   input wire logic [2:0] vec_sel,
   output logic vec_remap,
   output logic [15:0] vec_target
);
   localparam logic [20:0] QUIET_LAST = 21'(QUIET_CYCLES - 1);

   brl_pkg::brl_loader_s q_ff;
   brl_pkg::brl_loader_s nxt_q;
   logic pop;
   logic ser_push;

   brl_stream_if #(.WIDTH(8)) strm ();

   brl_fifo #(.WIDTH(8), .DEPTH(8)) u_fifo (
      .clock(clock),
      .reset(reset),
      .s(strm.fifo_side)
   );

   // serial bytes only enter in serial mode, parallel bytes from the cycle fsm
   assign strm.push_valid = (q_ff.mode == brl_pkg::MODE_SERIAL) ? ser_valid
                                                                : q_ff.push;
   assign strm.push_data = (q_ff.mode == brl_pkg::MODE_SERIAL) ? ser_data
      : q_ff.push_data;
   assign ser_push = ser_valid && strm.push_ready
                     && (q_ff.mode == brl_pkg::MODE_SERIAL);
   assign strm.pop_ready = ram_ready && (q_ff.st inside {brl_pkg::ST_HEAD,
      brl_pkg::ST_COUNT, brl_pkg::ST_EXT, brl_pkg::ST_PAR});
   assign pop = strm.pop_ready && strm.pop_valid;

   assign ser_ready = strm.push_ready;
   assign handshake_out_pin = q_ff.hs_out;
   assign par_addr = q_ff.par_addr;
   assign ram_we = q_ff.ram_we;
   assign ram_addr = q_ff.ram_addr;
   assign ram_wdata = q_ff.ram_wdata;
   assign run = q_ff.run;
   assign run_addr = q_ff.run_addr;
   assign vec_remap = q_ff.vec_remap;
   assign vec_target = q_ff.vec_target;

   // walks ram one, then two, then three
   function automatic logic [15:0] step_addr(input logic [15:0] a);
      logic [15:0] r;
      r = a + 16'h0001;
      if (a == `BRL_RAM1_END) begin
         r = `BRL_RAM2_START;
      end else if (a == `BRL_RAM2_END) begin
         r = `BRL_RAM3_START;
      end
      return r;
   endfunction

   always_comb begin
      nxt_q = q_ff;
      nxt_q.ram_we = 1'b0;
      nxt_q.push = 1'b0;
      nxt_q.tick = 1'b0;
      // pin synchronisers
      nxt_q.pd_s1 = {port_d_bit4, port_d_bit3, port_d_bit2};
      nxt_q.pd_s2 = q_ff.pd_s1;
      nxt_q.hs_s1 = handshake_in_pin;
      nxt_q.hs_s2 = q_ff.hs_s1;
      nxt_q.hs_prev = q_ff.hs_s2;
      nxt_q.dat_s1 = par_data;
      nxt_q.dat_s2 = q_ff.dat_s1;
      // machine cycle enable
      nxt_q.div = q_ff.div + 2'h1;
      nxt_q.tick = (q_ff.div == `BRL_MC_DIV_LAST);
      // interrupt vector redirection
      nxt_q.vec_remap = (q_ff.mode != brl_pkg::MODE_NONE);
      unique case (vec_sel)
         `BRL_SEL_SERIAL: nxt_q.vec_target = `BRL_VEC_SERIAL;
         `BRL_SEL_TOVF: nxt_q.vec_target = `BRL_VEC_TOVF;
         `BRL_SEL_OCMP: nxt_q.vec_target = `BRL_VEC_OCMP;
         `BRL_SEL_ICAP: nxt_q.vec_target = `BRL_VEC_ICAP;
         `BRL_SEL_EXT: nxt_q.vec_target = `BRL_VEC_EXT;
         default: nxt_q.vec_target = `BRL_VEC_TRAP;
      endcase
      // ram write of each popped byte after the header
      if (pop && q_ff.st != brl_pkg::ST_HEAD) begin
         nxt_q.ram_we = 1'b1;
         nxt_q.ram_addr = q_ff.wr_addr;
         nxt_q.ram_wdata = strm.pop_data;
         nxt_q.wr_addr = step_addr(q_ff.wr_addr);
      end
      unique case (q_ff.st)
         brl_pkg::ST_STRAP: begin
            // straps read once the synchroniser has filled
            if (q_ff.settle != `BRL_SETTLE_LAST) begin
               nxt_q.settle = q_ff.settle + 2'h1;
            end else if (q_ff.pd_s2[2:1] == 2'b11) begin
               nxt_q.mode = brl_pkg::MODE_SERIAL;
               nxt_q.st = brl_pkg::ST_HEAD;
            end else if (q_ff.pd_s2 == 3'b011) begin
               nxt_q.mode = brl_pkg::MODE_JUMP;
               nxt_q.st = brl_pkg::ST_RUN;
               nxt_q.run = 1'b1;
               nxt_q.run_addr = `BRL_EXEC_ADDR;
            end else if (q_ff.pd_s2 == 3'b010) begin
               nxt_q.mode = brl_pkg::MODE_PAR;
               nxt_q.st = brl_pkg::ST_PAR;
               nxt_q.mc = 6'h00;
               nxt_q.par_addr = `BRL_RAM1_START;
               nxt_q.wr_addr = `BRL_RAM1_START;
            end else begin
               nxt_q.st = brl_pkg::ST_IDLE;
            end
         end
         brl_pkg::ST_HEAD: begin
            nxt_q.wr_addr = `BRL_RAM1_START;
            nxt_q.quiet = '0;
            if (pop) begin
               if (strm.pop_data < `BRL_COUNT_LIMIT) begin
                  nxt_q.count = strm.pop_data;
                  nxt_q.st = (strm.pop_data == 8'h00) ? brl_pkg::ST_RUN
                                                      : brl_pkg::ST_COUNT;
                  nxt_q.run = (strm.pop_data == 8'h00);
                  nxt_q.run_addr = `BRL_EXEC_ADDR;
               end else begin
                  nxt_q.st = brl_pkg::ST_EXT;
               end
            end
         end
         brl_pkg::ST_COUNT: begin
            if (pop) begin
               nxt_q.count = q_ff.count - 8'h01;
               // count ends, or ram one is full
               if (q_ff.count == 8'h01 || q_ff.wr_addr == `BRL_RAM1_END) begin
                  nxt_q.st = brl_pkg::ST_RUN;
                  nxt_q.run = 1'b1;
                  nxt_q.run_addr = `BRL_EXEC_ADDR;
               end
            end
         end
         brl_pkg::ST_EXT: begin
            if (ser_push) begin
               nxt_q.quiet = '0;
            end else if (q_ff.quiet != QUIET_LAST) begin
               nxt_q.quiet = q_ff.quiet + 21'h00_0001;
            end
            if ((pop && q_ff.wr_addr == `BRL_RAM3_END)
                || (!pop && q_ff.quiet == QUIET_LAST)) begin
               nxt_q.st = brl_pkg::ST_RUN;
               nxt_q.run = 1'b1;
               nxt_q.run_addr = `BRL_EXEC_ADDR;
            end
         end
         brl_pkg::ST_PAR: begin
            if (q_ff.tick) begin
               if (q_ff.mc == `BRL_T_CR_LAST) begin
                  nxt_q.mc = 6'h00;
                  nxt_q.seen = 1'b0;
                  nxt_q.sampled = 1'b0;
                  // a cycle with no byte is repeated at the same address
                  if (q_ff.sampled && q_ff.par_addr != `BRL_RAM3_END) begin
                     nxt_q.par_addr = step_addr(q_ff.par_addr);
                  end
               end else begin
                  nxt_q.mc = q_ff.mc + 6'h01;
               end
               if (q_ff.mc == `BRL_T_HO) begin
                  nxt_q.hs_out = !q_ff.hs_out;
               end
            end
            // edge only counts after our own toggle and up to the limit
            if (q_ff.hs_s2 != q_ff.hs_prev && q_ff.mc > `BRL_T_HO
                && q_ff.mc <= `BRL_T_EXR) begin
               nxt_q.seen = 1'b1;
            end
            // sample once the address has settled, data valid per source
            if (q_ff.seen && !q_ff.sampled && q_ff.mc >= `BRL_T_ADR
                && strm.push_ready && !q_ff.push) begin
               nxt_q.push = 1'b1;
               nxt_q.push_data = q_ff.dat_s2;
               nxt_q.sampled = 1'b1;
            end
            if (pop && q_ff.wr_addr == `BRL_RAM3_END) begin
               nxt_q.st = brl_pkg::ST_RUN;
               nxt_q.run = 1'b1;
               nxt_q.run_addr = `BRL_EXEC_ADDR;
            end
         end
         brl_pkg::ST_RUN: begin
            nxt_q.run = 1'b1;
         end
         brl_pkg::ST_IDLE: begin
            nxt_q.run = 1'b0;
         end
         default: begin
            nxt_q.st = brl_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         q_ff <= '0;
      end else begin
         q_ff <= nxt_q;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   hs_out_delay_a: assert property (
      q_ff.st == brl_pkg::ST_PAR && q_ff.tick && q_ff.mc == `BRL_T_HO
      |=> handshake_out_pin != $past(handshake_out_pin))
      else $error("handshake out did not change at its delay");

   cycle_wrap_a: assert property (
      q_ff.st == brl_pkg::ST_PAR && q_ff.tick && q_ff.mc == `BRL_T_CR_LAST
      |=> q_ff.mc == 6'h00 && !q_ff.sampled)
      else $error("load cycle did not wrap at its length");

   count_window_a: assert property (
      q_ff.st == brl_pkg::ST_COUNT && pop
      |=> ram_we && ram_addr >= `BRL_RAM1_START && ram_addr <= `BRL_RAM1_END)
      else $error("count mode wrote outside ram one");

   ext_spill_a: assert property (
      q_ff.st == brl_pkg::ST_EXT && pop && q_ff.wr_addr == `BRL_RAM1_END
      |=> q_ff.wr_addr == `BRL_RAM2_START && q_ff.st == brl_pkg::ST_EXT)
      else $error("extended fill did not move to ram two");

   quiet_run_a: assert property (
      q_ff.st == brl_pkg::ST_EXT && !pop && q_ff.quiet == QUIET_LAST
      |=> run && run_addr == `BRL_EXEC_ADDR)
      else $error("quiet link did not start execution");

   slot_serial_a: assert property (
      vec_sel == `BRL_SEL_SERIAL && q_ff.mode != brl_pkg::MODE_NONE
      |=> vec_remap && vec_target == `BRL_VEC_SERIAL)
      else $error("serial vector not mapped to its slot");

   jump_entry_a: assert property (
      q_ff.st == brl_pkg::ST_STRAP && q_ff.settle == `BRL_SETTLE_LAST
      && q_ff.pd_s2 == 3'b011
      |=> run ##1 run && run_addr == `BRL_EXEC_ADDR)
      else $error("jump straps did not start execution");

   late_edge_a: assert property (
      $rose(q_ff.seen) |-> $past(q_ff.mc) <= `BRL_T_EXR)
      else $error("handshake edge taken after the window");
endmodule
`default_nettype wire

// File: sim/brl_host_model.sv
// host model feeding the parallel loader with tied handshake pins
`timescale 1ns/100ps
`default_nettype none
module brl_host_model (
   input wire logic clock,
   input wire logic [15:0] par_addr,
   input wire logic handshake_out_pin,
   output logic [7:0] par_data,
   output logic handshake_in_pin
);
   logic [15:0] last_addr;
   int delay;

   initial begin
      last_addr = 16'h0000;
      delay = 0;
      par_data = 8'h00;
   end

   // pins tied: each toggle is seen in the first machine cycle of the recognition window
   assign handshake_in_pin = handshake_out_pin;

   // data settles at most 14 machine cycles after a new address
   always @(posedge clock) begin
      if (par_addr !== last_addr) begin
         last_addr <= par_addr;
         delay <= $urandom % 57;
         par_data <= ~par_data;
      end else if (delay > 0) begin
         delay <= delay - 1;
         par_data <= ~par_data;
      end else begin
         par_data <= par_addr[7:0] ^ 8'h5a;
      end
   end
endmodule
`default_nettype wire

// File: sim/brl_loader_test.sv
// self-checking bench of the bootstrap ram loader
`timescale 1ns/100ps
`default_nettype none
module brl_loader_test;
   localparam int QUIET = 200;
   localparam logic [15:0] VEC_TAB [8] = '{16'h0054, 16'h0057, 16'h005a,
      16'h005d, 16'h0060, 16'h0063, 16'h0054, 16'h0054};
   logic clock, reset, ser_valid, ser_ready, handshake_in_pin, hs_q;
   logic handshake_out_pin, ram_ready, ram_we, run, vec_remap;
   logic [2:0] straps, vec_sel;
   logic [7:0] ser_data, par_data, ram_wdata;
   logic [15:0] par_addr, ram_addr, run_addr, vec_target, pa_q;
   int fails, total_checks, cyc, hs_t, e, pa_t;
   int exp_q[$];

   brl_loader #(.QUIET_CYCLES(QUIET)) u_brl_loader (
      .clock(clock), .reset(reset), .port_d_bit2(straps[0]),
      .port_d_bit3(straps[1]), .port_d_bit4(straps[2]),
      .ser_valid(ser_valid), .ser_data(ser_data), .ser_ready(ser_ready),
      .par_data(par_data), .handshake_in_pin(handshake_in_pin),
      .handshake_out_pin(handshake_out_pin), .par_addr(par_addr),
      .ram_ready(ram_ready), .ram_we(ram_we), .ram_addr(ram_addr),
      .ram_wdata(ram_wdata), .run(run), .run_addr(run_addr),
      .vec_sel(vec_sel), .vec_remap(vec_remap), .vec_target(vec_target));

   brl_host_model u_brl_host_model (.clock(clock), .par_addr(par_addr),
      .handshake_out_pin(handshake_out_pin), .par_data(par_data),
      .handshake_in_pin(handshake_in_pin));

   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   task results;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task cmp16(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: %h instead of %h", $time, got, exp);
      end
   endtask

   task cmp_write(input logic [15:0] ga, input logic [7:0] gd, input int ex);
      total_checks++;
      if ({ga, gd} !== 24'(ex)) begin
         fails++;
         $display("wrong value at %0t: %h instead of %h", $time, {ga, gd},
            24'(ex));
      end
   endtask

   function automatic int addr_of(int i);
      if (i < 176) return 16'h0050 + i;
      if (i < 432) return 16'h0100 + i - 176;
      return 16'h0250 + i - 432;
   endfunction

   // offer one byte, held until the edge that sees ready
   task send(input logic [7:0] b);
      int n;
      logic r;
      ser_valid = 1'b1;
      ser_data = b;
      n = 0;
      do begin
         r = ser_ready;
         @(negedge clock);
         n++;
      end while (r !== 1'b1 && n < 1000);
      if (r !== 1'b1) begin
         fails++;
         $display("serial byte never taken");
      end
   endtask

   task idle;
      ser_valid = 1'b0;
      ser_data = ~ser_data;
   endtask

   task do_reset(input logic [2:0] s);
      @(negedge clock);
      reset = 1'b1;
      straps = s;
      idle();
      exp_q.delete();
      repeat (10) @(negedge clock);
      reset = 1'b0;
      repeat (20) @(negedge clock);
   endtask

   task wait_run(input int lim);
      int n;
      n = 0;
      while (run !== 1'b1 && n < lim) begin
         @(negedge clock);
         n++;
      end
      // let the write monitor take the last write first
      @(negedge clock);
      cmp16({15'h0000, run}, 16'h0001);
      cmp16(run_addr, 16'h0051);
      cmp16(16'(exp_q.size()), 16'h0000);
   endtask

   // write monitor and handshake period monitor
   always @(negedge clock) begin
      cyc++;
      if (ram_we === 1'b1) begin
         e = exp_q.size() > 0 ? exp_q.pop_front() : -1;
         cmp_write(ram_addr, ram_wdata, e);
      end
      if (reset === 1'b1) begin
         hs_t = 0;
      end else if (handshake_out_pin !== hs_q) begin
         if (hs_t != 0) begin
            cmp16(16'(cyc - hs_t), 16'h00c4);
            cmp16(16'(cyc - pa_t), 16'h0018);
         end
         hs_t = cyc;
      end
      hs_q = handshake_out_pin;
      // cycle start is where the address moves on
      if (par_addr !== pa_q) begin
         pa_t = cyc;
      end
      pa_q = par_addr;
   end

   // ram stalls now and then
   always @(negedge clock) begin
      ram_ready <= ($urandom % 4) != 0;
   end

   initial begin
      repeat (20000) @(posedge clock);
      fails++;
      $display("watchdog expired");
      results();
   end

   initial begin
      logic [7:0] b;
      int n;
      reset = 1'b1;
      straps = 3'h0;
      vec_sel = 3'h0;
      ser_valid = 1'b0;
      ser_data = 8'h00;
      ram_ready = 1'b1;
      fails = 0;
      total_checks = 0;
      cyc = 0;
      hs_t = 0;
      hs_q = 1'b0;
      pa_t = 0;
      pa_q = 16'h0000;
      void'($urandom(73779));
      do_reset(3'h6);
      for (int i = 0; i < 8; i++) begin
         vec_sel = 3'(i);
         @(negedge clock);
         @(negedge clock);
         cmp16(vec_target, VEC_TAB[i]);
      end
      cmp16({15'h0000, vec_remap}, 16'h0001);
      n = 1 + $urandom % 20;
      send(8'(n));
      for (int i = 0; i < n; i++) begin
         b = 8'($urandom);
         exp_q.push_back((addr_of(i) << 8) | b);
         send(b);
      end
      idle();
      wait_run(300);
      $display("count load and vector test done");
      do_reset(3'h6);
      send(8'hb0 + 8'($urandom % 80));
      for (int i = 0; i < 608; i++) begin
         b = 8'($urandom);
         exp_q.push_back((addr_of(i) << 8) | b);
         send(b);
      end
      idle();
      wait_run(50);
      $display("full fill test done");
      do_reset(3'h6);
      send(8'hff);
      for (int i = 0; i < 5; i++) begin
         b = 8'($urandom);
         exp_q.push_back((addr_of(i) << 8) | b);
         send(b);
      end
      idle();
      repeat (QUIET - 50) @(negedge clock);
      cmp16({15'h0000, run}, 16'h0000);
      wait_run(100);
      $display("quiet line test done");
      do_reset(3'h3);
      wait_run(20);
      $display("jump test done");
      do_reset(3'h0);
      cmp16({15'h0000, vec_remap}, 16'h0000);
      cmp16({15'h0000, run}, 16'h0000);
      cmp16({15'h0000, ser_ready}, 16'h0001);
      $display("no loader strap test done");
      do_reset(3'h2);
      for (int i = 0; i < 4; i++) begin
         exp_q.push_back((addr_of(i) << 8) | ((8'h50 + i) ^ 8'h5a));
      end
      n = 0;
      while (exp_q.size() > 0 && n < 1400) begin
         @(negedge clock);
         n++;
      end
      cmp16(16'(exp_q.size()), 16'h0000);
      cmp16(par_addr, 16'h0053);
      $display("parallel load test done");
      results();
   end
endmodule
`default_nettype wire
